// [rtl/ingress_fifo_pkg.sv]
// Constants, register map and carrier types of the ingress FIFO control.
// Assumes one 100 MHz system clock and a 7-bit register address space.
package ingress_fifo_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] REG_MASTER_CONTROL = 7'h0f;
  localparam logic [6:0] REG_AGE_COUNTER = 7'h1f;
  localparam logic [6:0] REG_AGE_STEP = 7'h2f;
  localparam logic [6:0] REG_TRIGGER_SELECT = 7'h3f;
  localparam logic [6:0] REG_EVENT_COUNTER = 7'h4f;
  localparam logic [6:0] REG_BYPASS_MASK = 7'h5f;
  localparam logic [6:0] REG_CLASSIFIER = 7'h6f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_RESEND_HEADER = 13;
  localparam int CTL_BYPASS_INHIBIT = 12;
  localparam int CTL_PASS_FLOW = 11;
  localparam int CTL_MUTE_FULL_HALT = 7;
  localparam int CTL_POINTER_WIPE = 6;
  localparam int CTL_MAC_FAIL_DISREGARD = 18;
  localparam int TRG_PLANE_READ = 20;
  localparam int TRG_BAD_PLANE = 10;
  localparam int CLS_PAUSE_MARK = 24;
  localparam int AGE_STEP_WIDTH = 28;
  localparam int PORT_COUNT = 12;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0071;
  localparam logic [31:0] AGE_COUNTER_RESET = 32'h0000_0000;
  localparam logic [27:0] AGE_STEP_RESET = 28'h000_0000;
  localparam logic [7:0] TRIGGER_RESET = 8'h00;
  localparam logic [31:0] EVENT_COUNTER_RESET = 32'h0000_0000;
  localparam logic [11:0] BYPASS_MASK_RESET = 12'h000;
  localparam logic [24:0] CLASSIFIER_RESET = 25'h000_0000;

  // ----------------------------------------------------------------
  // Classifier constants and RAM sweep length
  // ----------------------------------------------------------------
  localparam logic [39:0] BRIDGE_PREFIX = 40'h01_80c2_0000;
  localparam logic [15:0] PAUSE_ETHERTYPE = 16'h8808;
  localparam logic [11:0] CLEAR_LAST_ADDR = 12'hfff;

  typedef enum logic [1:0] {KIND_START, KIND_MID, KIND_PARTIAL, KIND_END} plane_kind_e;

  typedef struct packed {
    logic valid;
    logic firstHalfValid;
    logic secondHalfValid;
    logic macFail;
    plane_kind_e kind;
    logic [3:0] port;
  } plane_s;

  typedef struct packed {
    logic valid;
    logic [47:0] dmac;
    logic [15:0] etherType;
  } header_s;

endpackage

// [rtl/ingress_fifo_control.sv]
// Ingress FIFO control: sequencing, gating, aging, debug and classifier.
// Assumes all inputs synchronous to sys_clk and a single-cycle register port.
`timescale 1ns/100ps
module ingress_fifo_control (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [6:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // Input plane stream and header fields
  input wire ingress_fifo_pkg::plane_s plane,
  input wire ingress_fifo_pkg::header_s header,
  // Output side events and per-buffer state
  input wire logic planeRead,
  input wire logic [11:0] inhibit,
  input wire logic fullStop,
  input wire logic [11:0] hostFlowStatus,
  input wire logic [11:0] headRenew,
  input wire logic [11:0] bufferOccupied,
  // Gating and forwarded status
  output logic [11:0] txEnable,
  output logic [11:0] flowStatusOut,
  output logic fifoActive,
  // RAM clear sweep
  output logic ramClearWe,
  output logic [11:0] ramClearAddr,
  // Plane sequencing results
  output logic frameDone,
  output logic lengthHeaderPlane,
  output logic sequenceError,
  output logic planeDrop,
  // Aging
  output logic ageTick,
  output logic [11:0] agedFrame,
  // Classifier
  output logic controlFrameMark
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] masterControl;
  logic [31:0] ageCounter;
  logic [27:0] ageStep;
  logic [7:0] triggerSelect;
  logic badPlaneSticky;
  logic [31:0] eventCounter;
  logic [11:0] bypassMask;
  logic [24:0] classifier;

  wire wrControl = regWr && regAddr == ingress_fifo_pkg::REG_MASTER_CONTROL;
  wire wrAgeCounter = regWr && regAddr == ingress_fifo_pkg::REG_AGE_COUNTER;
  wire wrAgeStep = regWr && regAddr == ingress_fifo_pkg::REG_AGE_STEP;
  wire wrTrigger = regWr && regAddr == ingress_fifo_pkg::REG_TRIGGER_SELECT;
  wire wrEventCounter = regWr && regAddr == ingress_fifo_pkg::REG_EVENT_COUNTER;
  wire wrBypassMask = regWr && regAddr == ingress_fifo_pkg::REG_BYPASS_MASK;
  wire wrClassifier = regWr && regAddr == ingress_fifo_pkg::REG_CLASSIFIER;

  wire resendHeader = masterControl[ingress_fifo_pkg::CTL_RESEND_HEADER];
  wire bypassInhibit = masterControl[ingress_fifo_pkg::CTL_BYPASS_INHIBIT];
  wire passFlow = masterControl[ingress_fifo_pkg::CTL_PASS_FLOW];
  wire muteFullHalt = masterControl[ingress_fifo_pkg::CTL_MUTE_FULL_HALT];
  wire pointerWipe = masterControl[ingress_fifo_pkg::CTL_POINTER_WIPE];
  wire failDisregard = masterControl[ingress_fifo_pkg::CTL_MAC_FAIL_DISREGARD];
  wire planeReadTrigger = triggerSelect[ingress_fifo_pkg::TRG_PLANE_READ - 16];
  wire pauseMarking = classifier[ingress_fifo_pkg::CLS_PAUSE_MARK];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      masterControl <= ingress_fifo_pkg::CONTROL_RESET;
      ageStep <= ingress_fifo_pkg::AGE_STEP_RESET;
      triggerSelect <= ingress_fifo_pkg::TRIGGER_RESET;
      bypassMask <= ingress_fifo_pkg::BYPASS_MASK_RESET;
      classifier <= ingress_fifo_pkg::CLASSIFIER_RESET;
    end else begin
      if (wrControl) masterControl <= regWrData;
      if (wrAgeStep) ageStep <= regWrData[27:0];
      if (wrTrigger) triggerSelect <= regWrData[23:16];
      if (wrBypassMask) bypassMask <= regWrData[11:0];
      if (wrClassifier) classifier <= regWrData[24:0];
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] readValue;
  always_comb begin
    unique case (regAddr)
      ingress_fifo_pkg::REG_MASTER_CONTROL: readValue = masterControl;
      ingress_fifo_pkg::REG_AGE_COUNTER: readValue = ageCounter;
      ingress_fifo_pkg::REG_AGE_STEP: readValue = {4'h0, ageStep};
      ingress_fifo_pkg::REG_TRIGGER_SELECT:
        readValue = {8'h00, triggerSelect, 5'h00, badPlaneSticky, 10'h000};
      ingress_fifo_pkg::REG_EVENT_COUNTER: readValue = eventCounter;
      ingress_fifo_pkg::REG_BYPASS_MASK: readValue = {20'h0_0000, bypassMask};
      ingress_fifo_pkg::REG_CLASSIFIER: readValue = {7'h00, classifier};
      default: readValue = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) regRdData <= 32'h0000_0000;
    else if (regRd) regRdData <= readValue;
    else regRdData <= 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // RAM clear sweep after reset
  // ----------------------------------------------------------------
  typedef enum logic {CLR_SWEEP, CLR_DONE} clear_state_e;
  clear_state_e clearState;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clearState <= CLR_SWEEP;
      ramClearAddr <= 12'h000;
      ramClearWe <= 1'b0;
    end else begin
      unique case (clearState)
        CLR_SWEEP: begin
          ramClearWe <= 1'b1;
          if (ramClearWe) ramClearAddr <= ramClearAddr + 12'h001;
          if (ramClearWe && ramClearAddr == ingress_fifo_pkg::CLEAR_LAST_ADDR) begin
            clearState <= CLR_DONE;
            ramClearWe <= 1'b0;
          end
        end
        CLR_DONE: ramClearWe <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output gating and flow status
  // ----------------------------------------------------------------
  // inactive while wiping or sweeping
  wire next_fifoActive = !pointerWipe && clearState == CLR_DONE;
  wire [11:0] inhibitHalt = inhibit & ~bypassMask & {12{!bypassInhibit}};
  wire fullHalt = fullStop && !muteFullHalt;
  wire [11:0] next_txEnable = {12{next_fifoActive && !fullHalt}} & ~inhibitHalt;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifoActive <= 1'b0;
      txEnable <= 12'h000;
      flowStatusOut <= 12'h000;
    end else begin
      fifoActive <= next_fifoActive;
      txEnable <= next_txEnable;
      flowStatusOut <= passFlow ? hostFlowStatus : 12'h000;
    end
  end

  // ----------------------------------------------------------------
  // Plane sequencing per input port
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_BODY, SEQ_WAIT_LEN} seq_state_e;
  seq_state_e seqState [ingress_fifo_pkg::PORT_COUNT];
  wire portOk = plane.valid && plane.port < 4'hc;
  wire isStart = plane.kind == ingress_fifo_pkg::KIND_START;
  wire isLast = plane.kind == ingress_fifo_pkg::KIND_END
    || plane.kind == ingress_fifo_pkg::KIND_PARTIAL;
  seq_state_e curSeq, next_seq;
  logic next_done, next_lenHeader, next_error;
  assign curSeq = portOk ? seqState[plane.port] : SEQ_IDLE;
  always_comb begin
    next_seq = curSeq;
    next_done = 1'b0;
    next_lenHeader = 1'b0;
    next_error = 1'b0;
    unique case (curSeq)
      SEQ_IDLE: begin
        if (isStart) next_seq = SEQ_BODY;
        else next_error = 1'b1;
      end
      SEQ_BODY: begin
        if (isStart) next_error = 1'b1;
        else if (isLast) begin
          next_seq = resendHeader ? SEQ_WAIT_LEN : SEQ_IDLE;
          next_done = !resendHeader;
        end
      end
      SEQ_WAIT_LEN: begin
        next_seq = SEQ_IDLE;
        next_lenHeader = isStart;
        next_done = isStart;
        next_error = !isStart;
      end
      default: begin
        next_seq = SEQ_IDLE;
        next_error = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < ingress_fifo_pkg::PORT_COUNT; p++) seqState[p] <= SEQ_IDLE;
    end else if (portOk) begin
      seqState[plane.port] <= next_seq;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frameDone <= 1'b0;
      lengthHeaderPlane <= 1'b0;
      sequenceError <= 1'b0;
      planeDrop <= 1'b0;
    end else begin
      frameDone <= portOk && next_done;
      lengthHeaderPlane <= portOk && next_lenHeader;
      sequenceError <= portOk && next_error;
      planeDrop <= portOk && plane.macFail && !failDisregard;
    end
  end

  // ----------------------------------------------------------------
  // Shared aging timer
  // ----------------------------------------------------------------
  logic halfRate;
  wire [32:0] ageSum = {1'b0, ageCounter} + {5'h00, ageStep};
  wire ageStepEnable = halfRate && ageStep != ingress_fifo_pkg::AGE_STEP_RESET;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      halfRate <= 1'b0;
      ageCounter <= ingress_fifo_pkg::AGE_COUNTER_RESET;
      ageTick <= 1'b0;
    end else begin
      halfRate <= !halfRate;
      ageTick <= !wrAgeCounter && ageStepEnable && ageSum[32];
      if (wrAgeCounter) ageCounter <= regWrData;
      else if (ageStepEnable) ageCounter <= ageSum[31:0];
    end
  end

  // ----------------------------------------------------------------
  // Per-buffer shadow registers
  // ----------------------------------------------------------------
  logic [11:0] shadowOne, shadowTwo;
  generate
    for (genvar b = 0; b < ingress_fifo_pkg::PORT_COUNT; b++) begin : g_buf
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          shadowOne[b] <= 1'b0;
          shadowTwo[b] <= 1'b0;
          agedFrame[b] <= 1'b0;
        end else begin
          if (headRenew[b]) begin
            shadowOne[b] <= 1'b0;
            shadowTwo[b] <= 1'b0;
          end else if (ageTick) begin
            shadowOne[b] <= 1'b1;
            shadowTwo[b] <= shadowOne[b];
          end
          // aged after one to two periods
          agedFrame[b] <= shadowTwo[b] && bufferOccupied[b] && !headRenew[b];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Debug triggers, sticky flag and event counter
  // ----------------------------------------------------------------
  // plane read event
  wire planeReadEvent = planeReadTrigger && planeRead;
  wire badPlaneSeen = plane.valid && !plane.firstHalfValid && plane.secondHalfValid;
  wire badPlaneClear = wrTrigger && regWrData[ingress_fifo_pkg::TRG_BAD_PLANE];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) badPlaneSticky <= 1'b0;
    else if (badPlaneSeen) badPlaneSticky <= 1'b1;
    else if (badPlaneClear) badPlaneSticky <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) eventCounter <= ingress_fifo_pkg::EVENT_COUNTER_RESET;
    else if (wrEventCounter) eventCounter <= regWrData;
    else if (planeReadEvent) eventCounter <= eventCounter + 32'h0000_0001;
  end

  // ----------------------------------------------------------------
  // Control frame classifier
  // ----------------------------------------------------------------
  wire prefixHit = header.dmac[47:8] == ingress_fifo_pkg::BRIDGE_PREFIX;
  wire [3:0] lowNibble = header.dmac[3:0];
  wire [1:0] blockSel = header.dmac[5:4];
  wire blockOk = header.dmac[7:6] == 2'b00 && blockSel != 2'b11;
  wire [7:0] blockMask = 8'({7'h00, classifier} >> (8 * blockSel));
  wire singleHit = lowNibble < 4'h7 && blockMask[lowNibble[2:0]];
  wire dmacHit = header.valid && prefixHit && blockOk && (blockMask[7] || singleHit);
  wire pauseHit = header.valid && pauseMarking
    && header.etherType == ingress_fifo_pkg::PAUSE_ETHERTYPE;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) controlFrameMark <= 1'b0;
    else controlFrameMark <= dmacHit || pauseHit;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_secondTickHeld;
    (ageTick && shadowOne[0] && !headRenew[0]) ##1 (bufferOccupied[0] && !headRenew[0]);
  endsequence

  AST_LEN_HEADER: assert property (@(posedge sys_clk) disable iff (!rst_n)
    portOk && curSeq == SEQ_WAIT_LEN && isStart |=> lengthHeaderPlane && frameDone)
    else $error("length header plane not flagged");
  AST_INHIBIT_HALT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    inhibit[3] && !bypassInhibit && !bypassMask[3] |=> !txEnable[3])
    else $error("inhibit did not halt buffer 3");
  AST_FLOW_PASS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    passFlow |=> flowStatusOut == $past(hostFlowStatus))
    else $error("flow status not forwarded");
  AST_FULL_STOP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fullStop && !muteFullHalt |=> txEnable == 12'h000)
    else $error("full stop did not halt output");
  AST_WIPE_INACTIVE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pointerWipe || clearState == CLR_SWEEP |=> !fifoActive)
    else $error("FIFO active while wiping or sweeping");
  AST_AGE_STEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ageStepEnable && !wrAgeCounter |=> ageCounter == $past(ageSum[31:0]))
    else $error("age counter did not add step");
  AST_TICK_SPACING: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ageTick |=> !ageTick)
    else $error("age ticks on adjacent cycles");
  AST_ZERO_STEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ageStep == 28'h000_0000 |=> !ageTick)
    else $error("tick with zero step");
  AST_SHADOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ageTick && !headRenew[0] |=> shadowOne[0] && shadowTwo[0] == $past(shadowOne[0]))
    else $error("shadow registers not updated on tick");
  AST_AGED: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_secondTickHeld |=> agedFrame[0])
    else $error("frame not aged after two ticks");
  AST_BAD_PLANE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    badPlaneSeen |=> badPlaneSticky)
    else $error("bad plane sticky not set");
  AST_STICKY_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    badPlaneSticky && !badPlaneClear |=> badPlaneSticky)
    else $error("sticky flag lost without clear");
  AST_EVENT_COUNT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    planeReadEvent && !wrEventCounter |=> eventCounter == $past(eventCounter) + 32'h0000_0001)
    else $error("event counter not incremented by one");
  AST_PAUSE_MARK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pauseHit |=> controlFrameMark)
    else $error("pause frame not marked");
  AST_GROUP_MARK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    header.valid && header.dmac == 48'h0180_c200_0003 && classifier[3] |=> controlFrameMark)
    else $error("bridge group address not marked");

endmodule

// [testbench/mac_plane_source.sv]
// Plane source standing in for the tri-speed MAC side of the FIFO.
// Assumes the bench requests one plane per cycle on sys_clk.
`timescale 1ns/100ps
module mac_plane_source (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Request from bench
  input wire logic sendReq,
  input wire ingress_fifo_pkg::plane_s sendPlane,
  // Plane toward the block
  output ingress_fifo_pkg::plane_s plane
);
  // one plane a cycle
  // Idle payload toggles so stale fields never look held
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      plane <= '0;
    end else if (sendReq) begin
      plane <= sendPlane;
    end else begin
      plane <= ingress_fifo_pkg::plane_s'({1'b0, ~plane[8:0]});
    end
  end
endmodule

// [testbench/tb_ingress_fifo_control.sv]
// Self-checking bench for the ingress FIFO control.
// Assumes a 100 MHz clock and the single-cycle register port.
`timescale 1ns/100ps
module tb_ingress_fifo_control;
  logic sys_clk = 0, rst_n = 0, regWr = 0, regRd = 0, planeRead = 0, fullStop = 0, sendReq = 0;
  logic [6:0] regAddr = '0;
  logic [31:0] regWrData = '0, regRdData;
  logic [11:0] inhibit = '0, hostFlowStatus = '0, headRenew = '0, bufferOccupied = '0;
  logic [11:0] txEnable, flowStatusOut, ramClearAddr, agedFrame;
  logic fifoActive, ramClearWe, frameDone, lengthHeaderPlane, sequenceError, planeDrop;
  logic ageTick, controlFrameMark;
  ingress_fifo_pkg::plane_s sendPlane = '0, plane;
  ingress_fifo_pkg::header_s header = '0;
  int numErrors = 0, comparisons = 0, cycles = 0, doneCnt = 0, pairCnt = 0, dropCnt = 0;
  int markCnt = 0, tickCnt = 0, tickAt = 0, errCnt = 0, weCnt = 0;
  mac_plane_source mac_plane_source_inst (.sys_clk(sys_clk), .rst_n(rst_n), .sendReq(sendReq),
    .sendPlane(sendPlane), .plane(plane));
  ingress_fifo_control ingress_fifo_control_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .plane(plane), .header(header), .planeRead(planeRead),
    .inhibit(inhibit), .fullStop(fullStop), .hostFlowStatus(hostFlowStatus),
    .headRenew(headRenew), .bufferOccupied(bufferOccupied), .txEnable(txEnable),
    .flowStatusOut(flowStatusOut), .fifoActive(fifoActive), .ramClearWe(ramClearWe),
    .ramClearAddr(ramClearAddr), .frameDone(frameDone), .lengthHeaderPlane(lengthHeaderPlane),
    .sequenceError(sequenceError), .planeDrop(planeDrop), .ageTick(ageTick),
    .agedFrame(agedFrame), .controlFrameMark(controlFrameMark));
  always #5 sys_clk = ~sys_clk;
  // ----------------------------------------
  // Pulse counters and hang guard
  // ----------------------------------------
  always @(posedge sys_clk) begin
    cycles++;
    doneCnt += int'(frameDone === 1'b1);
    pairCnt += int'(frameDone === 1'b1 && lengthHeaderPlane === 1'b1);
    dropCnt += int'(planeDrop === 1'b1);
    markCnt += int'(controlFrameMark === 1'b1);
    tickCnt += int'(ageTick === 1'b1);
    errCnt += int'(sequenceError === 1'b1);
    weCnt += int'(ramClearWe === 1'b1);
    if (cycles == 30000) begin
      numErrors++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    check(regRdData, exp);
  endtask
  task automatic send(input ingress_fifo_pkg::plane_kind_e k, input logic fh, sh, fail);
    @(posedge sys_clk);
    sendReq <= 1'b1;
    sendPlane <= '{valid: 1'b1, firstHalfValid: fh, secondHalfValid: sh, macFail: fail,
      kind: k, port: 4'h2};
    @(posedge sys_clk);
    sendReq <= 1'b0;
    settle(3);
  endtask
  task automatic hdr(input logic [31:0] cls, input logic [47:0] dmac, input logic [15:0] et,
      input int exp);
    int base;
    wr(ingress_fifo_pkg::REG_CLASSIFIER, cls);
    base = markCnt;
    @(posedge sys_clk);
    header <= '{valid: 1'b1, dmac: dmac, etherType: et};
    @(posedge sys_clk);
    header <= '{valid: 1'b0, dmac: ~dmac, etherType: ~et};
    settle(3);
    check(32'(markCnt - base), 32'(exp));
  endtask
  task automatic test_reset_and_wipe();
    rdchk(ingress_fifo_pkg::REG_MASTER_CONTROL, 32'h0000_0071);
    rdchk(ingress_fifo_pkg::REG_AGE_STEP, 32'h0000_0000);
    rdchk(7'h7f, 32'h0000_0000);
    check({31'h0, ramClearWe}, 32'h0000_0001);
    check({20'h0, ramClearAddr}, 32'h0000_0005);
    settle(12000);
    check({30'h0, ramClearWe, fifoActive}, 32'h0000_0000);
    check(32'(weCnt), 32'h0000_1000);
    wr(ingress_fifo_pkg::REG_MASTER_CONTROL, 32'h0000_0011);
    settle(3);
    check({31'h0, fifoActive}, 32'h0000_0001);
    $display("test reset and wipe done");
  endtask
  task automatic test_gating();
    @(posedge sys_clk);
    inhibit <= 12'h008;
    settle(3);
    check({20'h0, txEnable}, 32'h0000_0ff7);
    wr(ingress_fifo_pkg::REG_BYPASS_MASK, 32'h0000_0008);
    settle(3);
    check({20'h0, txEnable}, 32'h0000_0fff);
    wr(ingress_fifo_pkg::REG_BYPASS_MASK, 32'h0000_0000);
    wr(ingress_fifo_pkg::REG_MASTER_CONTROL, 32'h0000_1011);
    settle(3);
    check({20'h0, txEnable}, 32'h0000_0fff);
    @(posedge sys_clk);
    fullStop <= 1'b1;
    settle(3);
    check({20'h0, txEnable}, 32'h0000_0000);
    wr(ingress_fifo_pkg::REG_MASTER_CONTROL, 32'h0000_1891);
    hostFlowStatus <= 12'ha5a;
    settle(3);
    check({20'h0, txEnable}, 32'h0000_0fff);
    check({20'h0, flowStatusOut}, 32'h0000_0a5a);
    wr(ingress_fifo_pkg::REG_MASTER_CONTROL, 32'h0000_0011);
    settle(3);
    check({20'h0, flowStatusOut}, 32'h0000_0000);
    @(posedge sys_clk);
    fullStop <= 1'b0;
    inhibit <= 12'h000;
    $display("test gating done");
  endtask
  task automatic test_planes();
    send(ingress_fifo_pkg::KIND_START, 1'b1, 1'b1, 1'b0);
    send(ingress_fifo_pkg::KIND_MID, 1'b1, 1'b1, 1'b0);
    send(ingress_fifo_pkg::KIND_END, 1'b1, 1'b1, 1'b0);
    check(32'(doneCnt), 32'h0000_0001);
    wr(ingress_fifo_pkg::REG_MASTER_CONTROL, 32'h0000_2011);
    send(ingress_fifo_pkg::KIND_START, 1'b1, 1'b1, 1'b1);
    send(ingress_fifo_pkg::KIND_MID, 1'b0, 1'b1, 1'b0);
    send(ingress_fifo_pkg::KIND_END, 1'b1, 1'b1, 1'b0);
    check(32'(doneCnt), 32'h0000_0001);
    send(ingress_fifo_pkg::KIND_START, 1'b1, 1'b1, 1'b0);
    check(32'(pairCnt), 32'h0000_0001);
    check(32'(dropCnt), 32'h0000_0001);
    rdchk(ingress_fifo_pkg::REG_TRIGGER_SELECT, 32'h0000_0400);
    wr(ingress_fifo_pkg::REG_TRIGGER_SELECT, 32'h0010_0400);
    rdchk(ingress_fifo_pkg::REG_TRIGGER_SELECT, 32'h0010_0000);
    wr(ingress_fifo_pkg::REG_MASTER_CONTROL, 32'h0004_0011);
    send(ingress_fifo_pkg::KIND_START, 1'b1, 1'b1, 1'b1);
    check(32'(dropCnt), 32'h0000_0001);
    send(ingress_fifo_pkg::KIND_START, 1'b1, 1'b1, 1'b0);
    check(32'(errCnt), 32'h0000_0001);
    send(ingress_fifo_pkg::KIND_PARTIAL, 1'b1, 1'b1, 1'b0);
    check(32'(doneCnt), 32'h0000_0003);
    repeat (3) begin
      @(posedge sys_clk);
      planeRead <= 1'b1;
      @(posedge sys_clk);
      planeRead <= 1'b0;
    end
    rdchk(ingress_fifo_pkg::REG_EVENT_COUNTER, 32'h0000_0003);
    $display("test planes and debug done");
  endtask
  task automatic test_aging();
    @(posedge sys_clk);
    bufferOccupied <= 12'h001;
    headRenew <= 12'h001;
    @(posedge sys_clk);
    headRenew <= 12'h000;
    wr(ingress_fifo_pkg::REG_AGE_STEP, 32'h0800_0000);
    for (int i = 0; i < 200 && tickCnt < 1; i++) settle(1);
    tickAt = cycles;
    settle(2);
    check({20'h0, agedFrame}, 32'h0000_0000);
    for (int i = 0; i < 200 && tickCnt < 2; i++) settle(1);
    check(32'(cycles - tickAt), 32'h0000_0040);
    settle(2);
    check({20'h0, agedFrame}, 32'h0000_0001);
    wr(ingress_fifo_pkg::REG_AGE_STEP, 32'h0000_0000);
    settle(200);
    check(32'(tickCnt), 32'h0000_0002);
    $display("test aging done");
  endtask
  task automatic test_classify();
    hdr(32'h0000_0008, 48'h0180_c200_0003, 16'h0800, 1);
    hdr(32'h0000_0008, 48'h0180_c200_0004, 16'h0800, 0);
    hdr(32'h0000_0080, 48'h0180_c200_000e, 16'h0800, 1);
    hdr(32'h0000_8000, 48'h0180_c200_001f, 16'h0800, 1);
    hdr(32'h0000_1000, 48'h0180_c200_0014, 16'h0800, 1);
    hdr(32'h0040_0000, 48'h0180_c200_0026, 16'h0800, 1);
    hdr(32'h0080_0000, 48'h0180_c200_002b, 16'h0800, 1);
    hdr(32'h0100_0000, 48'h0a00_0000_0001, 16'h8808, 1);
    hdr(32'h0000_0000, 48'h0a00_0000_0001, 16'h8808, 0);
    $display("test classify done");
  endtask
  task automatic give_verdict();
    $display("counts: comparisons=%0d mismatches=%0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    test_reset_and_wipe();
    test_gating();
    test_planes();
    test_aging();
    test_classify();
    give_verdict();
  end
endmodule
